// ===== verilog/panel_pkg.sv
/*
  Constants shared by the front-panel status block: register offsets, field
  positions, reset values, display codes and timing counts.
  Assumes a 250 MHz core clock and a 32-bit AHB-Lite register bus.
*/
package panel_pkg;

    // Clock and blink timing
    localparam int CLK_HZ            = 250_000_000;
    localparam int FAULT_BLINK_PER_S = 4;
    localparam int BLINK_HALF_CYCLES = CLK_HZ / (FAULT_BLINK_PER_S * 2);
    localparam int BLINK_CNT_W       = 25;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] NODE_OFS   = 8'h04;
    localparam logic [7:0] ADDR_OFS   = 8'h08;
    localparam logic [7:0] STATUS_OFS = 8'h0c;
    localparam logic [7:0] PMAP_OFS   = 8'h10;
    localparam logic [7:0] ODICT_OFS  = 8'h14;

    // Control register fields
    localparam int CTRL_NODE_SRC_BIT = 0;
    localparam int CTRL_MON_SEL_BIT  = 1;
    localparam int CTRL_AXIS2_BIT    = 2;
    localparam int CTRL_ONLINE_BIT   = 3;
    localparam int CTRL_INIT_BIT     = 4;
    localparam int CTRL_W            = 5;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;

    // Node address parameter reset value
    localparam logic [6:0] NODE_RESET = 7'h01;

    // Axis address arithmetic
    localparam logic [6:0] TENS_WEIGHT  = 7'd10;
    localparam logic [6:0] AUTO_ADDRESS = 7'd0;

    // Object dictionary mapping
    localparam logic [15:0] ODICT_BASE   = 16'h2000;
    localparam logic [7:0]  SUBIDX_PLUS  = 8'h01;

    // Status display codes
    localparam logic [3:0] STAT_RESET     = 4'h0;
    localparam logic [3:0] NOT_READY_CODE = 4'h1;
    localparam logic [3:0] READY_CODE     = 4'h2;
    localparam logic [3:0] RUNNING_CODE   = 4'h3;
    localparam logic [3:0] ONLINE_CODE    = 4'h4;

    // Control mode codes
    localparam logic [3:0] CM_PROFILE_POS  = 4'h1;
    localparam logic [3:0] CM_PROFILE_VEL  = 4'h3;
    localparam logic [3:0] CM_PROFILE_TRQ  = 4'h4;
    localparam logic [3:0] CM_HOMING       = 4'h6;
    localparam logic [3:0] CM_CYCLIC_POS   = 4'h8;
    localparam logic [3:0] CM_CYCLIC_VEL   = 4'h9;
    localparam logic [3:0] CM_CYCLIC_TRQ   = 4'ha;

    // Fieldbus state codes
    localparam logic [3:0] FB_INIT     = 4'h1;
    localparam logic [3:0] FB_PREOP    = 4'h2;
    localparam logic [3:0] FB_SAFEOP   = 4'h4;
    localparam logic [3:0] FB_OP       = 4'h8;

    // Keypad display modes, one-hot
    typedef enum logic [3:0] {
        MODE_STATUS  = 4'b0001,
        MODE_PARAM   = 4'b0010,
        MODE_FAULT   = 4'b0100,
        MODE_MONITOR = 4'b1000
    } disp_mode_e;

    // Health indicator colours
    localparam logic [1:0] HEALTH_OFF   = 2'b00;
    localparam logic [1:0] HEALTH_GREEN = 2'b01;
    localparam logic [1:0] HEALTH_RED   = 2'b10;

endpackage

// ===== verilog/axis_addr_calc.sv
/*
  One decimal switch pair to a binary address, plus a flag for the
  drive-assigned (zero) case. Assumes switch digits are 0..9.
*/
`timescale 1ns/1ps
module axis_addr_calc (
    // Switch digits
    input  wire logic [3:0] tens_i,
    input  wire logic [3:0] units_i,
    // Result
    output wire logic [6:0] addr_o,
    output wire logic       auto_o
);
    // Tens times ten plus units; digits above 9 are the switch's problem
    wire logic [6:0] tens_val;
    assign tens_val = 7'(tens_i * panel_pkg::TENS_WEIGHT);
    assign addr_o   = 7'(tens_val + {3'h0, units_i});
    assign auto_o   = (addr_o == panel_pkg::AUTO_ADDRESS);
endmodule // axis_addr_calc

// ===== verilog/servo_panel.sv
/*
  Front-panel status and address logic of a two-axis servo drive: switch
  address capture, indicators, keypad display-mode sequencer, status and
  code encoding, parameter-to-object-dictionary mapping, AHB-Lite registers.
  Assumes keys arrive as one-cycle pulses, synchronous to ref_clk_i.
*/
// Implementation choices: the register addresses and the AHB-Lite register port.
// What this block does
// - Axis address is tens*10 plus units; 00 auto
// - First pair feeds axis 1, second axis 2
// - Node source 1 uses first pair, else parameter
// - One node address shared by both axes
// - Direction indicator on during reverse rotation
// - Health green when normal, red blink 4/s fault
// - Axis dot off for axis 1, on axis 2
// - Dictionary index is 0x2000 plus group
// - Subindex is offset within group plus one
// - Keypad starts in status display mode
// - Mode key advances to next display mode
// - Status to monitoring while turning if mon_sel, back on stop
// - Parameter mode selecting monitor enters monitoring
// - Fault blinks all digits; enter stops; mode->param
// - Reset state shown without axis, leaves when init_done is set
// - Not-ready code while main power absent
// - Ready code waits servo-on, then running code
// - Control mode shown as one hex digit
// - Fieldbus state shown as 1,2,4,8 code
// - Online code while commissioning tool selects drive
`timescale 1ns/1ps
module servo_panel (
    // Clock, reset, enable
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        clk_en_i,
    // AHB-Lite slave
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic      [31:0] hrdata_o,
    output wire logic        hreadyout_o,
    output wire logic        hresp_o,
    // Address switches
    input  wire logic [3:0]  first_pair_tens_switch_i,
    input  wire logic [3:0]  first_pair_units_switch_i,
    input  wire logic [3:0]  second_pair_tens_switch_i,
    input  wire logic [3:0]  second_pair_units_switch_i,
    // Keys, one-cycle pulses
    input  wire logic        mode_key_i,
    input  wire logic        enter_key_i,
    // Drive state
    input  wire logic        main_power_ok_i,
    input  wire logic        servo_on_i,
    input  wire logic        motor_turning_i,
    input  wire logic        reverse_i,
    input  wire logic        fault_i,
    input  wire logic [3:0]  control_mode_i,
    input  wire logic [3:0]  fieldbus_state_i,
    input  wire logic        outbound_port_link_i,
    input  wire logic        inbound_port_link_i,
    // Indicators
    output logic             run_indicator_o,
    output logic             direction_indicator_o,
    output logic      [1:0]  health_indicator_o,
    output logic             axis_dot_o,
    output logic             outbound_port_seg_o,
    output logic             inbound_port_seg_o,
    // Display content
    output logic      [3:0]  disp_mode_o,
    output logic             digits_blink_o,
    output logic      [3:0]  status_code_o,
    output logic             show_axis_o,
    output logic      [3:0]  control_mode_code_o,
    output logic      [3:0]  fieldbus_code_o,
    // Addresses
    output logic      [6:0]  axis1_address_o,
    output logic      [6:0]  axis2_address_o,
    output logic             axis1_auto_o,
    output logic             axis2_auto_o,
    output logic      [6:0]  node_address_o
);

    // Bus and control storage
    logic [panel_pkg::CTRL_W-1:0] ctrl;
    logic [6:0]                   node_param;
    logic [15:0]                  pmap;
    logic                         dp_write;
    logic                         dp_read;
    logic [7:0]                   dp_addr;

    // Sampled switches
    logic [3:0] sw1_tens;
    logic [3:0] sw1_units;
    logic [3:0] sw2_tens;
    logic [3:0] sw2_units;
    logic       sampled;

    // Keypad sequencer state
    panel_pkg::disp_mode_e mode;
    panel_pkg::disp_mode_e next_mode;
    logic                  blink_on;
    logic                  next_blink_on;
    logic                  fault_seen;
    logic [panel_pkg::BLINK_CNT_W-1:0] blink_cnt;
    logic                  blink_phase;

    // Control fields
    wire logic node_src   = ctrl[panel_pkg::CTRL_NODE_SRC_BIT];
    wire logic mon_sel    = ctrl[panel_pkg::CTRL_MON_SEL_BIT];
    wire logic axis2_sel  = ctrl[panel_pkg::CTRL_AXIS2_BIT];
    wire logic online     = ctrl[panel_pkg::CTRL_ONLINE_BIT];
    wire logic init_done  = ctrl[panel_pkg::CTRL_INIT_BIT];

    // Address decoding from sampled switches
    wire logic [6:0] a1_addr;
    wire logic [6:0] a2_addr;
    wire logic       a1_auto;
    wire logic       a2_auto;

    axis_addr_calc u_axis1 (
        .tens_i  (sw1_tens),
        .units_i (sw1_units),
        .addr_o  (a1_addr),
        .auto_o  (a1_auto)
    );

    axis_addr_calc u_axis2 (
        .tens_i  (sw2_tens),
        .units_i (sw2_units),
        .addr_o  (a2_addr),
        .auto_o  (a2_auto)
    );

    // One node address for the drive, chosen by source bit
    wire logic [6:0] node_addr = node_src ? a1_addr : node_param;

    // Switch capture once after reset release; held until next reset
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            sampled   <= 1'b0;
            sw1_tens  <= 4'h0;
            sw1_units <= 4'h0;
            sw2_tens  <= 4'h0;
            sw2_units <= 4'h0;
        end else if (clk_en_i && !sampled) begin
            sampled   <= 1'b1;
            sw1_tens  <= first_pair_tens_switch_i;
            sw1_units <= first_pair_units_switch_i;
            sw2_tens  <= second_pair_tens_switch_i;
            sw2_units <= second_pair_units_switch_i;
        end
    end

    // AHB-Lite decode; zero wait states, always OKAY
    wire logic bus_take  = hsel_i && hready_i && htrans_i[1];
    wire logic hit_ctrl  = dp_addr == panel_pkg::CTRL_OFS;
    wire logic hit_node  = dp_addr == panel_pkg::NODE_OFS;
    wire logic hit_pmap  = dp_addr == panel_pkg::PMAP_OFS;
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;

    // Address phase capture
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            dp_write <= 1'b0;
            dp_read  <= 1'b0;
            dp_addr  <= 8'h00;
        end else if (clk_en_i) begin
            dp_write <= bus_take && hwrite_i;
            dp_read  <= bus_take && !hwrite_i;
            dp_addr  <= haddr_i[7:0];
        end
    end

    // Register writes in the data phase
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            ctrl       <= panel_pkg::CTRL_RESET;
            node_param <= panel_pkg::NODE_RESET;
            pmap       <= 16'h0000;
        end else if (clk_en_i && dp_write) begin
            if (hit_ctrl) begin
                ctrl <= hwdata_i[panel_pkg::CTRL_W-1:0];
            end else if (hit_node) begin
                node_param <= hwdata_i[6:0];
            end else if (hit_pmap) begin
                pmap <= hwdata_i[15:0];
            end
        end
    end

    // Parameter number to dictionary index and subindex
    wire logic [15:0] od_index  = 16'(panel_pkg::ODICT_BASE + {8'h00, pmap[15:8]});
    wire logic [7:0]  od_subidx = 8'(pmap[7:0] + panel_pkg::SUBIDX_PLUS);

    // Read mux; unmapped offsets read zero
    wire logic [31:0] rd_val =
        hit_ctrl                            ? {27'h0, ctrl} :
        hit_node                            ? {25'h0, node_addr} :
        (dp_addr == panel_pkg::ADDR_OFS)    ? {15'h0, a2_auto, a2_addr, 1'b0, a1_auto, a1_addr} :
        (dp_addr == panel_pkg::STATUS_OFS)  ? {24'h0, status_code_o, disp_mode_o} :
        hit_pmap                            ? {16'h0, pmap} :
        (dp_addr == panel_pkg::ODICT_OFS)   ? {8'h00, od_index, od_subidx} :
                                              32'h0000_0000;

    always_comb begin
        hrdata_o = dp_read ? rd_val : 32'h0000_0000;
    end

    // Display mode sequencer; fault entry outranks everything
    always_comb begin
        next_mode     = mode;
        next_blink_on = blink_on;
        if (fault_i && !fault_seen) begin
            next_mode     = panel_pkg::MODE_FAULT;
            next_blink_on = 1'b1;
        end else begin
            case (mode)
                panel_pkg::MODE_STATUS: begin
                    if (mode_key_i) begin
                        next_mode = panel_pkg::MODE_PARAM;
                    end else if (mon_sel && motor_turning_i) begin
                        next_mode = panel_pkg::MODE_MONITOR;
                    end
                end
                panel_pkg::MODE_PARAM: begin
                    if (mode_key_i) begin
                        next_mode = panel_pkg::MODE_FAULT;
                    end else if (mon_sel) begin
                        next_mode = panel_pkg::MODE_MONITOR;
                    end
                end
                panel_pkg::MODE_FAULT: begin
                    if (enter_key_i) begin
                        next_blink_on = 1'b0;
                    end else if (mode_key_i) begin
                        next_mode     = blink_on ? panel_pkg::MODE_FAULT
                                                 : panel_pkg::MODE_PARAM;
                    end
                end
                panel_pkg::MODE_MONITOR: begin
                    if (mode_key_i) begin
                        next_mode = panel_pkg::MODE_STATUS;
                    end else if (!motor_turning_i && mon_sel) begin
                        next_mode = panel_pkg::MODE_STATUS;
                    end
                end
                default: begin
                    next_mode = panel_pkg::MODE_STATUS;
                end
            endcase
        end
    end

    // Sequencer registers; fault_seen makes fault entry edge-triggered
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            mode       <= panel_pkg::MODE_STATUS;
            blink_on   <= 1'b0;
            fault_seen <= 1'b0;
        end else if (clk_en_i) begin
            mode       <= next_mode;
            blink_on   <= next_blink_on;
            fault_seen <= fault_i;
        end
    end

    // Fault blink timebase: phase toggles eight times a second
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            blink_cnt   <= '0;
            blink_phase <= 1'b0;
        end else if (clk_en_i) begin
            if (blink_cnt == panel_pkg::BLINK_CNT_W'(panel_pkg::BLINK_HALF_CYCLES - 1)) begin
                blink_cnt   <= '0;
                blink_phase <= ~blink_phase;
            end else begin
                blink_cnt <= blink_cnt + 1'b1;
            end
        end
    end

    // Status code: reset, online, not ready, running, ready
    wire logic [3:0] status_val =
        !init_done       ? panel_pkg::STAT_RESET :
        online           ? panel_pkg::ONLINE_CODE :
        !main_power_ok_i ? panel_pkg::NOT_READY_CODE :
        servo_on_i       ? panel_pkg::RUNNING_CODE :
                           panel_pkg::READY_CODE;

    wire logic running = init_done && main_power_ok_i && servo_on_i && !fault_i;

    // Control modes outside the documented set show as zero
    wire logic cm_valid =
        (control_mode_i == panel_pkg::CM_PROFILE_POS) || (control_mode_i == panel_pkg::CM_PROFILE_VEL) ||
        (control_mode_i == panel_pkg::CM_PROFILE_TRQ) || (control_mode_i == panel_pkg::CM_HOMING) ||
        (control_mode_i == panel_pkg::CM_CYCLIC_POS) || (control_mode_i == panel_pkg::CM_CYCLIC_VEL) ||
        (control_mode_i == panel_pkg::CM_CYCLIC_TRQ);
    wire logic fb_valid =
        (fieldbus_state_i == panel_pkg::FB_INIT) || (fieldbus_state_i == panel_pkg::FB_PREOP) ||
        (fieldbus_state_i == panel_pkg::FB_SAFEOP) || (fieldbus_state_i == panel_pkg::FB_OP);

    // Registered outputs: indicators, codes, addresses
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            run_indicator_o       <= 1'b0;
            direction_indicator_o <= 1'b0;
            health_indicator_o    <= panel_pkg::HEALTH_OFF;
            axis_dot_o            <= 1'b0;
            outbound_port_seg_o   <= 1'b0;
            inbound_port_seg_o    <= 1'b0;
            status_code_o         <= panel_pkg::STAT_RESET;
            show_axis_o           <= 1'b0;
            control_mode_code_o   <= 4'h0;
            fieldbus_code_o       <= 4'h0;
            axis1_address_o       <= 7'h00;
            axis2_address_o       <= 7'h00;
            axis1_auto_o          <= 1'b0;
            axis2_auto_o          <= 1'b0;
            node_address_o        <= 7'h00;
        end else if (clk_en_i) begin
            run_indicator_o       <= running;
            direction_indicator_o <= running && reverse_i;
            health_indicator_o    <= fault_i ? (blink_phase ? panel_pkg::HEALTH_RED
                                                            : panel_pkg::HEALTH_OFF)
                                             : panel_pkg::HEALTH_GREEN;
            axis_dot_o            <= init_done && axis2_sel;
            outbound_port_seg_o   <= outbound_port_link_i;
            inbound_port_seg_o    <= inbound_port_link_i;
            status_code_o         <= status_val;
            show_axis_o           <= init_done;
            control_mode_code_o   <= cm_valid ? control_mode_i : 4'h0;
            fieldbus_code_o       <= fb_valid ? fieldbus_state_i : 4'h0;
            axis1_address_o       <= a1_addr;
            axis2_address_o       <= a2_addr;
            axis1_auto_o          <= a1_auto;
            axis2_auto_o          <= a2_auto;
            node_address_o        <= node_addr;
        end
    end

    // Mode and blink straight from sequencer flops
    always_comb begin
        disp_mode_o    = mode;
        digits_blink_o = (mode == panel_pkg::MODE_FAULT) && blink_on && blink_phase;
    end

endmodule // servo_panel

// ===== verif/op_host_model.sv
/* Keypad and host controller model for the servo front panel.
   Assumes requests change just after a rising edge of clk_i. */
`timescale 1ns/1ps
module op_host_model (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    // Bench requests and drive status
    input  wire logic       mode_req_i,
    input  wire logic       enter_req_i,
    input  wire logic       servo_req_i,
    input  wire logic [3:0] status_code_i,
    // Towards the drive
    output logic            mode_key_o,
    output logic            enter_key_o,
    output logic            servo_on_o
);
    logic       mode_q, enter_q;
    logic [3:0] wait_cnt;
    // Edge detect, so a held request never repeats a key
    always_ff @(posedge clk_i) begin
        mode_q      <= mode_req_i;
        enter_q     <= enter_req_i;
        mode_key_o  <= rst_n_i & mode_req_i & ~mode_q;
        enter_key_o <= rst_n_i & enter_req_i & ~enter_q;
    end
    // Host is slow: servo-on only five cycles after ready shows
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !servo_req_i) begin
            wait_cnt   <= 4'h0;
            servo_on_o <= 1'b0;
        end else if (status_code_i == panel_pkg::READY_CODE || wait_cnt != 4'h0) begin
            wait_cnt   <= wait_cnt + 4'h1;
            servo_on_o <= servo_on_o | (wait_cnt == 4'h5);
        end
    end
endmodule // op_host_model

// ===== verif/panel_monitor.sv
/* Port checker for servo_panel, bound to every instance.
   Assumes clk_en_i is held high. */
`timescale 1ns/1ps
module panel_monitor (
    // Clock and reset
    input wire logic       ref_clk_i,
    input wire logic       rst_n_i,
    // Inputs watched
    input wire logic       mode_key_i,
    input wire logic       enter_key_i,
    input wire logic       motor_turning_i,
    input wire logic       reverse_i,
    input wire logic       fault_i,
    input wire logic       outbound_port_link_i,
    // Outputs watched
    input wire logic       run_indicator_o,
    input wire logic       direction_indicator_o,
    input wire logic [1:0] health_indicator_o,
    input wire logic [3:0] disp_mode_o,
    input wire logic       outbound_port_seg_o
);
    logic blinking;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    // Digits blink from a fault rise until enter
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) blinking <= 1'b0;
        else if ($rose(fault_i)) blinking <= 1'b1;
        else if (enter_key_i) blinking <= 1'b0;
    end
    a_run_fault: assert property (fault_i |=> !run_indicator_o)
        else $error("run lit in fault");
    a_dir_forward: assert property (!reverse_i |=> !direction_indicator_o)
        else $error("direction lit forward");
    a_health_normal: assert property (!fault_i |=> health_indicator_o == panel_pkg::HEALTH_GREEN)
        else $error("health not green");
    a_health_fault: assert property (fault_i |=> health_indicator_o != panel_pkg::HEALTH_GREEN)
        else $error("health green in fault");
    a_link_lit: assert property ($rose(outbound_port_link_i) |=> outbound_port_seg_o)
        else $error("link segment not lit");
    a_fault_entry: assert property ($rose(fault_i) |=> disp_mode_o == panel_pkg::MODE_FAULT)
        else $error("no fault display");
    a_mode_step: assert property (mode_key_i && !fault_i && !motor_turning_i &&
        disp_mode_o == panel_pkg::MODE_STATUS |=> disp_mode_o == panel_pkg::MODE_PARAM)
        else $error("mode key ignored");
    a_blink_hold: assert property (blinking && mode_key_i &&
        disp_mode_o == panel_pkg::MODE_FAULT |=> disp_mode_o == panel_pkg::MODE_FAULT)
        else $error("fault display left");
endmodule // panel_monitor
bind servo_panel panel_monitor mon_u (.*);

// ===== verif/testbench.sv
/* Self-checking bench for servo_panel over AHB-Lite and the keypad model.
   Assumes the checker binds itself. */
`timescale 1ns/1ps
module testbench;
    // Inputs named as ports, for .*
    logic             ref_clk_i = 1'b0, rst_n_i = 1'b0, clk_en_i = 1'b1, hsel_i = 1'b0, hwrite_i = 1'b0;
    logic [1:0]       htrans_i = 2'h0;
    logic [2:0]       hsize_i = 3'h2;
    logic [31:0]      haddr_i = 32'h0, hwdata_i = 32'h0, rd;
    logic [3:0]       first_pair_tens_switch_i = 4'h4, first_pair_units_switch_i = 4'h2;
    logic [3:0]       second_pair_tens_switch_i = 4'h0, second_pair_units_switch_i = 4'h0;
    logic [3:0]       control_mode_i = 4'h0, fieldbus_state_i = 4'h0;
    logic             main_power_ok_i = 1'b0, motor_turning_i = 1'b0, reverse_i = 1'b0, fault_i = 1'b0;
    logic             outbound_port_link_i = 1'b0, inbound_port_link_i = 1'b0;
    logic             mode_req = 1'b0, enter_req = 1'b0, servo_req = 1'b0;
    // Outputs, plus DUT inputs driven by the keypad model or the ready assign
    wire logic [31:0] hrdata_o;
    wire logic        hready_i, hreadyout_o, hresp_o, mode_key_i, enter_key_i, servo_on_i, show_axis_o;
    wire logic        run_indicator_o, direction_indicator_o, axis_dot_o, outbound_port_seg_o;
    wire logic        inbound_port_seg_o, digits_blink_o, axis1_auto_o, axis2_auto_o;
    wire logic [1:0]  health_indicator_o;
    wire logic [3:0]  disp_mode_o, status_code_o, control_mode_code_o, fieldbus_code_o;
    wire logic [6:0]  axis1_address_o, axis2_address_o, node_address_o;
    int               n_fail = 0, checked = 0;
    // Codes; first seven and first four legal
    logic [3:0]       cm_in [8] = '{4'h1, 4'h3, 4'h4, 4'h6, 4'h8, 4'h9, 4'ha, 4'h2};
    logic [3:0]       fb_in [8] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'h0, 4'hf, 4'h5};
    logic [15:0]      pm [3] = '{16'h0000, 16'h0109, 16'h020f};
    logic [31:0]      od [3] = '{32'h0020_0001, 32'h0020_010a, 32'h0020_0210};
    // Single slave: its ready is the bus ready
    assign hready_i = hreadyout_o;
    always #2 ref_clk_i = ~ref_clk_i;
    servo_panel dut_u (.*);
    op_host_model partner_u (.clk_i(ref_clk_i), .rst_n_i(rst_n_i), .mode_req_i(mode_req),
        .enter_req_i(enter_req), .servo_req_i(servo_req), .status_code_i(status_code_o),
        .mode_key_o(mode_key_i), .enter_key_o(enter_key_i), .servo_on_o(servo_on_i));
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask
    // Bounded wait for ready
    task automatic wait_rdy;
        int i = 0;
        do begin
            @(posedge ref_clk_i);
            i++;
        end while (hready_i !== 1'b1 && i < 20);
        if (hready_i !== 1'b1) begin
            n_fail++;
            complete_run;
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel_i   <= 1'b1;
        haddr_i  <= {24'h0, a};
        htrans_i <= 2'h2;
        hwrite_i <= w;
        wait_rdy;
        hsel_i   <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= wd;
        wait_rdy;
        rd = hrdata_o;
    endtask
    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(what, rd, exp);
    endtask
    task automatic press(input logic enter);
        {enter_req, mode_req} <= {enter, !enter};
        tick(1);
        {enter_req, mode_req} <= 2'b00;
        tick(4);
    endtask
    task automatic ctl(input logic [31:0] v);
        bus(1'b1, panel_pkg::CTRL_OFS, v);
        tick(2);
    endtask
    // Main sequence
    initial begin
        tick(3);
        rst_n_i <= 1'b1;
        tick(3);
        chk("mode", disp_mode_o, panel_pkg::MODE_STATUS);
        chk("status", status_code_o, panel_pkg::STAT_RESET);
        chk("show axis", show_axis_o, 1'b0);
        chk("response", {hresp_o, hreadyout_o}, 2'h1);
        rdchk("ctrl", panel_pkg::CTRL_OFS, 32'h0);
        rdchk("node reg", panel_pkg::NODE_OFS, 32'h1);
        bus(1'b1, panel_pkg::ADDR_OFS, 32'hffff_ffff);
        rdchk("addr reg", panel_pkg::ADDR_OFS, 32'h0001_002a);
        rdchk("unmapped", 8'h20, 32'h0);
        first_pair_tens_switch_i <= 4'h9;
        tick(2);
        chk("axis1", axis1_address_o, 7'h2a);
        chk("axis2 auto", {axis2_auto_o, axis2_address_o}, 8'h80);
        ctl(32'h11);
        chk("node", node_address_o, 7'h2a);
        bus(1'b1, panel_pkg::NODE_OFS, 32'h15);
        rdchk("node reg", panel_pkg::NODE_OFS, 32'h2a);
        ctl(32'h10);
        chk("node", node_address_o, 7'h15);
        $display("test addresses done");
        chk("status", status_code_o, panel_pkg::NOT_READY_CODE);
        chk("show axis", show_axis_o, 1'b1);
        main_power_ok_i <= 1'b1;
        tick(3);
        chk("status", status_code_o, panel_pkg::READY_CODE);
        servo_req <= 1'b1;
        tick(12);
        chk("status", status_code_o, panel_pkg::RUNNING_CODE);
        chk("run", run_indicator_o, 1'b1);
        chk("health", health_indicator_o, panel_pkg::HEALTH_GREEN);
        reverse_i <= 1'b1;
        tick(2);
        chk("direction", direction_indicator_o, 1'b1);
        rdchk("status reg", panel_pkg::STATUS_OFS, 32'h31);
        ctl(32'h18);
        chk("status", status_code_o, panel_pkg::ONLINE_CODE);
        ctl(32'h14);
        chk("axis dot", axis_dot_o, 1'b1);
        ctl(32'h10);
        chk("axis dot", axis_dot_o, 1'b0);
        for (int i = 0; i < 8; i++) begin
            control_mode_i       <= cm_in[i];
            fieldbus_state_i     <= fb_in[i];
            outbound_port_link_i <= i[0];
            inbound_port_link_i  <= i[1];
            tick(3);
            chk("mode code", control_mode_code_o, i < 7 ? cm_in[i] : 4'h0);
            chk("bus code", fieldbus_code_o, i < 4 ? fb_in[i] : 4'h0);
            chk("links", {outbound_port_seg_o, inbound_port_seg_o}, {i[0], i[1]});
        end
        $display("test status done");
        motor_turning_i <= 1'b1;
        press(1'b0);
        chk("mode", disp_mode_o, panel_pkg::MODE_PARAM);
        ctl(32'h12);
        chk("mode", disp_mode_o, panel_pkg::MODE_MONITOR);
        for (int i = 0; i < 3; i++) begin
            motor_turning_i <= i[0];
            tick(2);
            chk("mode", disp_mode_o, i[0] ? panel_pkg::MODE_MONITOR : panel_pkg::MODE_STATUS);
        end
        ctl(32'h10);
        fault_i <= 1'b1;
        tick(2);
        chk("mode", disp_mode_o, panel_pkg::MODE_FAULT);
        chk("run", run_indicator_o, 1'b0);
        press(1'b0);
        chk("mode", disp_mode_o, panel_pkg::MODE_FAULT);
        press(1'b1);
        press(1'b0);
        chk("mode", disp_mode_o, panel_pkg::MODE_PARAM);
        fault_i <= 1'b0;
        $display("test keypad done");
        for (int i = 0; i < 3; i++) begin
            bus(1'b1, panel_pkg::PMAP_OFS, {16'h0, pm[i]});
            rdchk("odict", panel_pkg::ODICT_OFS, od[i]);
        end
        $display("test dictionary done");
        complete_run;
    end
endmodule // testbench
